// ==== hw/fcf_top.sv ====
// Cascadable nine-bit clocked FIFO with programming path, parity and APB status
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
// Operation
// - Write clock edge with enable and room stores the nine input bits
// - Active-low write enable gates every write clock edge, program mode too
// - Active-low read enable gates every read clock edge, program mode too
// - Read clock edge with enable and data presents the next word
// - Write edge during config reset loads the configuration instead of memory
// - Read edge during config reset shows configuration on the outputs
// - Parity generation replaces the ninth input bit with a computed parity
// - Ninth output is data, generated parity, or parity error by mode
// - Half, almost-full and full flags change only on write clock edges
// - Empty and almost-empty flags change only on read clock edges
// - Half-full output follows the write clock
// - Combined output: empty on read clock, full on write clock
// - Standalone almost pin: almost-full on write, almost-empty on read clock
// - Cascaded, the almost pin becomes the cascade-out to the next device
// - Standalone, a low strobe on first-load/replay restarts reading from start
// - Config reset empties buffer and restores no parity, threshold sixteen
// - Three status outputs decode to six fill states
module fcf_top
    import fcf_pkg::*;
#(
    parameter int DEPTH = FCF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_clock,
    input wire logic read_clock,
    input wire logic write_enable_n,
    input wire logic read_enable_n,
    input wire logic config_reset,
    input wire logic [FCF_DATA_W-1:0] input_word,
    output logic [7:0] output_bits,
    output logic ninth_output_bit,
    output logic half_full_flag,
    output logic empty_full_n,
    output logic almost_flag_or_cascade_out_n,
    input wire logic cascade_in_n,
    input wire logic first_load_or_replay
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
    localparam logic [CW-1:0] ONE_CNT = CW'(1);

    fcf_pins_t pins_raw;
    fcf_pins_t pins_s;
    fcf_pins_t prev_q;
    fcf_cfg_t cfg_q;
    fcf_flags_t flags;
    logic casc_q;
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [CW-1:0] thr_cnt;
    logic [FCF_DATA_W-1:0] wr_word;
    logic [FCF_DATA_W-1:0] rd_word;
    logic [FCF_DATA_W-1:0] out_q;
    logic empty_q, aempty_q, half_q, afull_q, full_q;
    logic wtok_q, rtok_q, xo_q;
    logic [1:0] init_q;
    logic [31:0] prdata_q;
    logic w_edge, r_edge, mr_rise, fl_fall, xi_fall;
    logic wr_acc, rd_acc, replay, cfg_wr, cfg_rd;
    logic w_pass, r_pass, unmapped;

    // Every pin from outside passes two flip-flops first
    assign pins_raw = '{wclk: write_clock, rclk: read_clock, wen_n: write_enable_n,
                        ren_n: read_enable_n, mr: config_reset, xi_n: cascade_in_n,
                        fl: first_load_or_replay, d: input_word};

    fcf_sync #(
        .W($bits(fcf_pins_t)),
        .INIT(FCF_PINS_IDLE)
    ) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // Previous synchronised levels for edge detection
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prev_q <= FCF_PINS_IDLE;
        end else begin
            prev_q <= pins_s;
        end
    end

    // Pin clock edges; data was synchronised with the same latency
    assign w_edge = pins_s.wclk & ~prev_q.wclk;
    assign r_edge = pins_s.rclk & ~prev_q.rclk;
    assign mr_rise = pins_s.mr & ~prev_q.mr;
    assign fl_fall = prev_q.fl & ~pins_s.fl;
    assign xi_fall = prev_q.xi_n & ~pins_s.xi_n;

    // Qualified operations
    assign cfg_wr = w_edge & ~pins_s.wen_n & pins_s.mr;
    assign cfg_rd = r_edge & ~pins_s.ren_n & pins_s.mr;
    assign wr_acc = w_edge & ~pins_s.wen_n & ~pins_s.mr & (cnt_q != FULL_CNT)
                    & (~casc_q | wtok_q);
    assign rd_acc = r_edge & ~pins_s.ren_n & ~pins_s.mr & (cnt_q != '0)
                    & (~casc_q | rtok_q);
    // Replay relies on the controller holding both enables high meanwhile
    assign replay = fl_fall & ~casc_q & ~pins_s.mr;

    // Write token leaves when this device fills; read token when it drains
    assign w_pass = casc_q & wr_acc & (cnt_q == FULL_CNT - ONE_CNT);
    assign r_pass = casc_q & rd_acc & (cnt_q == ONE_CNT) & ~wtok_q;

    // Parity generation substitutes the ninth stored bit
    assign wr_word = (cfg_q.par_en & cfg_q.par_gen)
                     ? {(^pins_s.d[7:0]) ^ FCF_PAR_ODD, pins_s.d[7:0]} : pins_s.d;

    fcf_mem #(
        .W(FCF_DATA_W),
        .DEPTH(DEPTH)
    ) u_mem (
        .clk_sys(clk_sys),
        .wr_en(wr_acc),
        .wr_addr(wr_ptr_q),
        .wr_data(wr_word),
        .rd_addr(rd_ptr_q),
        .rd_data(rd_word)
    );

    // Next fill level; replay rebuilds it from the write pointer
    always_comb begin
        cnt_d = cnt_q;
        if (pins_s.mr) begin
            cnt_d = '0;
        end else if (replay) begin
            cnt_d = (wr_ptr_q == '0 && cnt_q != '0) ? FULL_CNT : CW'(wr_ptr_q);
        end else if (wr_acc && !rd_acc) begin
            cnt_d = cnt_q + ONE_CNT;
        end else if (rd_acc && !wr_acc) begin
            cnt_d = cnt_q - ONE_CNT;
        end
    end

    // Pointers and level
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            if (pins_s.mr) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
            end else begin
                if (wr_acc) begin
                    wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
                end
                if (replay) begin
                    rd_ptr_q <= '0;
                end else if (rd_acc) begin
                    rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
                end
            end
        end
    end

    // Configuration: defaults on config reset, pin programming, then APB
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= FCF_CFG_RESET;
        end else if (mr_rise) begin
            cfg_q <= FCF_CFG_RESET;
        end else if (cfg_wr) begin
            cfg_q <= fcf_cfg_t'(pins_s.d);
        end else if (psel && penable && pwrite && paddr == FCF_OFS_CFG) begin
            cfg_q <= fcf_cfg_t'(pwdata[FCF_DATA_W-1:0]);
        end
    end

    // Threshold as a level count
    assign thr_cnt = CW'(cfg_q.thresh);

    // Write-side flags move only on write clock edges
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            half_q <= FCF_FLAGS_RESET.half;
            afull_q <= FCF_FLAGS_RESET.almost_full;
            full_q <= FCF_FLAGS_RESET.full;
        end else if (pins_s.mr) begin
            half_q <= 1'b0;
            afull_q <= 1'b0;
            full_q <= 1'b0;
        end else if (w_edge) begin
            half_q <= cnt_d > HALF_CNT;
            afull_q <= cnt_d >= FULL_CNT - thr_cnt;
            full_q <= cnt_d == FULL_CNT;
        end
    end

    // Read-side flags move only on read clock edges
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            empty_q <= FCF_FLAGS_RESET.empty;
            aempty_q <= FCF_FLAGS_RESET.almost_empty;
        end else if (pins_s.mr) begin
            empty_q <= 1'b1;
            aempty_q <= 1'b1;
        end else if (r_edge) begin
            empty_q <= cnt_d == '0;
            aempty_q <= cnt_d <= thr_cnt;
        end
    end

    // Output word register: memory data, parity view, or configuration
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            out_q <= '0;
        end else if (cfg_rd) begin
            out_q <= FCF_DATA_W'(cfg_q);
        end else if (rd_acc) begin
            out_q[7:0] <= rd_word[7:0];
            if (cfg_q.par_en && !cfg_q.par_gen) begin
                out_q[FCF_PAR_BIT] <= ((^rd_word[7:0]) ^ FCF_PAR_ODD) != rd_word[FCF_PAR_BIT];
            end else begin
                out_q[FCF_PAR_BIT] <= rd_word[FCF_PAR_BIT];
            end
        end
    end

    // Strap settle counter; the strap is sampled while the synchroniser still holds its idle value
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            init_q <= '0;
        end else if (init_q != FCF_INIT_CYC) begin
            init_q <= init_q + 2'h1;
        end
    end

    // Cascade tokens; chain head is marked by a low first-load strap at a config reset rise
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wtok_q <= FCF_FLAGS_RESET.wtok;
            rtok_q <= FCF_FLAGS_RESET.rtok;
        end else if (mr_rise || init_q == FCF_INIT_CYC - 2'h1) begin
            wtok_q <= ~pins_s.fl;
            rtok_q <= ~pins_s.fl;
        end else if (casc_q) begin
            if (w_pass) begin
                wtok_q <= 1'b0;
            end else if (xi_fall && !wtok_q && !rtok_q && cnt_q == '0) begin
                wtok_q <= 1'b1;
            end
            if (r_pass) begin
                rtok_q <= 1'b0;
            end else if (xi_fall && (wtok_q || cnt_q != '0)) begin
                rtok_q <= 1'b1;
            end
        end
    end

    // One-cycle cascade-out pulse per token hand-off
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            xo_q <= 1'b0;
        end else begin
            xo_q <= w_pass | r_pass;
        end
    end

    // Control register: cascade mode select
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            casc_q <= 1'b0;
        end else if (psel && penable && pwrite && paddr == FCF_OFS_CTRL) begin
            casc_q <= pwdata[FCF_CTRL_CASC_BIT];
        end
    end

    assign flags = '{rtok: rtok_q, wtok: wtok_q, empty: empty_q, almost_empty: aempty_q,
                     half: half_q, almost_full: afull_q, full: full_q};

    // Read data captured in the setup phase so it is steady in the access phase
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata_q <= '0;
        end else if (psel && !penable) begin
            case (paddr)
                FCF_OFS_CTRL: prdata_q <= 32'(casc_q);
                FCF_OFS_CFG: prdata_q <= 32'(cfg_q);
                FCF_OFS_STAT: prdata_q <= 32'(flags);
                FCF_OFS_LEVEL: prdata_q <= 32'(cnt_q);
                default: prdata_q <= '0;
            endcase
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error
    assign unmapped = paddr != FCF_OFS_CTRL && paddr != FCF_OFS_CFG
                      && paddr != FCF_OFS_STAT && paddr != FCF_OFS_LEVEL;
    assign pready = 1'b1;
    assign pslverr = psel & penable & unmapped;
    assign prdata = prdata_q;

    // Pin outputs; the three status pins decode to six fill states
    assign output_bits = out_q[7:0];
    assign ninth_output_bit = out_q[FCF_PAR_BIT];
    assign half_full_flag = half_q;
    assign empty_full_n = ~(empty_q | full_q);
    assign almost_flag_or_cascade_out_n = casc_q ? ~xo_q : ~(afull_q | aempty_q);
endmodule // fcf_top

// ==== hw/fcf_pkg.sv ====
// Shared constants, register map and carrier types for the clocked FIFO block
package fcf_pkg;
    // Storage geometry
    localparam int FCF_DATA_W = 9;
    localparam int FCF_DEPTH = 512;
    localparam int FCF_PAR_BIT = 8;
    // Parity sense: 0 gives even parity over the low eight bits
    localparam logic FCF_PAR_ODD = 1'b0;
    // Cycles after reset release before the first-load strap is trusted
    localparam logic [1:0] FCF_INIT_CYC = 2'h2;

    // Programming word: parity enable, generate/check select, threshold
    typedef struct packed {
        logic par_en;
        logic par_gen;
        logic [6:0] thresh;
    } fcf_cfg_t;
    localparam fcf_cfg_t FCF_CFG_RESET = '{par_en: 1'b0, par_gen: 1'b0, thresh: 7'h10};

    // Pin bundle as it passes through the synchroniser
    typedef struct packed {
        logic wclk;
        logic rclk;
        logic wen_n;
        logic ren_n;
        logic mr;
        logic xi_n;
        logic fl;
        logic [FCF_DATA_W-1:0] d;
    } fcf_pins_t;
    localparam fcf_pins_t FCF_PINS_IDLE = '{wclk: 1'b0, rclk: 1'b0, wen_n: 1'b1, ren_n: 1'b1,
                                            mr: 1'b0, xi_n: 1'b1, fl: 1'b1, d: 9'h000};

    // Status flags: the two cascade tokens, then one per decoded level
    typedef struct packed {
        logic rtok;
        logic wtok;
        logic empty;
        logic almost_empty;
        logic half;
        logic almost_full;
        logic full;
    } fcf_flags_t;
    localparam fcf_flags_t FCF_FLAGS_RESET = '{rtok: 1'b0, wtok: 1'b0, empty: 1'b1, almost_empty: 1'b1,
                                               half: 1'b0, almost_full: 1'b0, full: 1'b0};

    // APB register byte offsets
    localparam logic [11:0] FCF_OFS_CTRL = 12'h000;
    localparam logic [11:0] FCF_OFS_CFG = 12'h004;
    localparam logic [11:0] FCF_OFS_STAT = 12'h008;
    localparam logic [11:0] FCF_OFS_LEVEL = 12'h00C;
    localparam int FCF_CTRL_CASC_BIT = 0;
endpackage

// ==== hw/fcf_sync.sv ====
// Two-stage synchroniser for a bundle of asynchronous pin inputs
`timescale 1ns/100ps
module fcf_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    meta_q[i] <= INIT[i];
                    sync_out[i] <= INIT[i];
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule // fcf_sync

// ==== hw/fcf_mem.sv ====
// Word store for the FIFO: one clocked write port, one combinational read port
`timescale 1ns/100ps
module fcf_mem #(
    parameter int W = 9,
    parameter int DEPTH = 512,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [DEPTH];

    // No reset on the array; contents are only read after being written
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule // fcf_mem

// ==== verif/fcf_checker.sv ====
// Concurrent checks on the FIFO pin flags, data outputs and APB handshake
`timescale 1ns/100ps
module fcf_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic pready,
    input wire logic write_clock,
    input wire logic read_clock,
    input wire logic read_enable_n,
    input wire logic config_reset,
    input wire logic [7:0] output_bits,
    input wire logic ninth_output_bit,
    input wire logic half_full_flag,
    input wire logic empty_full_n,
    input wire logic almost_flag_or_cascade_out_n
);
    logic [2:0] wc_age;
    logic [2:0] rc_age;
    logic [2:0] mr_age;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Cycles since each pin was last high, saturating so old edges stay old
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) wc_age <= 3'h7;
        else if (write_clock) wc_age <= 3'h0;
        else if (wc_age != 3'h7) wc_age <= wc_age + 3'h1;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) rc_age <= 3'h7;
        else if (read_clock) rc_age <= 3'h0;
        else if (rc_age != 3'h7) rc_age <= rc_age + 3'h1;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) mr_age <= 3'h7;
        else if (config_reset) mr_age <= 3'h0;
        else if (mr_age != 3'h7) mr_age <= mr_age + 3'h1;
    end
    a_pready_high: assert property (psel |-> pready)
        else $error("pready low during a transfer");
    a_flags_mr: assert property (config_reset [*4] |-> !empty_full_n && !half_full_flag)
        else $error("flags not empty under config reset");
    a_almost_mr: assert property (config_reset [*4] |-> !almost_flag_or_cascade_out_n)
        else $error("almost pin high under config reset");
    a_half_wclk: assert property ($changed(half_full_flag) |-> wc_age < 3'h6 || mr_age < 3'h6)
        else $error("half flag moved without a write clock");
    a_ef_clocked: assert property ($changed(empty_full_n) |-> wc_age < 3'h6 || rc_age < 3'h6 || mr_age < 3'h6)
        else $error("empty/full moved without a pin clock");
    a_ef_steady: assert property ((!write_clock && !read_clock && !config_reset) [*7] |-> $stable(empty_full_n))
        else $error("empty/full changed while clocks idle");
    a_out_hold: assert property ((read_enable_n && !config_reset) [*6] |-> $stable({ninth_output_bit, output_bits}))
        else $error("outputs changed with read disabled");
    a_full_almost: assert property (half_full_flag && !empty_full_n |-> !almost_flag_or_cascade_out_n)
        else $error("full without almost flag");
endmodule // fcf_checker

// ==== verif/fcf_peer.sv ====
// Writing and reading logic that drives the FIFO pin ports
`timescale 1ns/100ps
module fcf_peer
    import fcf_pkg::*;
(
    input wire logic clk_sys,
    output logic write_clock,
    output logic read_clock,
    output logic write_enable_n,
    output logic read_enable_n,
    output logic [FCF_DATA_W-1:0] input_word,
    output logic first_load_or_replay
);
    // Idle: clocks still, enables off, strap high for a lone part
    initial begin
        write_clock = 1'b0;
        read_clock = 1'b0;
        write_enable_n = 1'b1;
        read_enable_n = 1'b1;
        input_word = 9'h000;
        first_load_or_replay = 1'b1;
    end
    // One write-clock period; pins stay 4 cycles so the sync never misses them
    task automatic pw(input logic en_n, input logic [FCF_DATA_W-1:0] d, input int g);
        write_enable_n <= en_n;
        input_word <= d;
        repeat (3 + g) @(posedge clk_sys);
        write_clock <= 1'b1;
        repeat (4) @(posedge clk_sys);
        write_clock <= 1'b0;
        repeat (3) @(posedge clk_sys);
        write_enable_n <= 1'b1;
        input_word <= ~d; // Released bus must not keep the old word
        @(posedge clk_sys);
    endtask
    // One read-clock period
    task automatic pr(input logic en_n, input int g);
        read_enable_n <= en_n;
        repeat (3 + g) @(posedge clk_sys);
        read_clock <= 1'b1;
        repeat (4) @(posedge clk_sys);
        read_clock <= 1'b0;
        repeat (3) @(posedge clk_sys);
        read_enable_n <= 1'b1;
        @(posedge clk_sys);
    endtask
    // Replay strobe with both enables parked high
    task automatic replay();
        write_enable_n <= 1'b1;
        read_enable_n <= 1'b1;
        first_load_or_replay <= 1'b0;
        repeat (4) @(posedge clk_sys);
        first_load_or_replay <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule // fcf_peer

// ==== verif/fcf_tb.sv ====
// Self-checking bench for the FIFO: programming, parity, replay, fill and APB
`timescale 1ns/100ps
module testbench
    import fcf_pkg::*;
;
    localparam int DEPTH = 32;
    logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, config_reset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic write_clock, read_clock, write_enable_n, read_enable_n, first_load_or_replay;
    logic [8:0] input_word, q;
    logic [7:0] output_bits;
    logic ninth_output_bit, half_full_flag, empty_full_n, almost_pin, er;
    int miscompares = 0;
    int tests_run = 0;
    // Rows: word driven in generate mode, word expected back
    logic [17:0] rows [4] = '{{9'h100, 9'h000}, {9'h001, 9'h101}, {9'h1FF, 9'h0FF}, {9'h07F, 9'h17F}};
    assign q = {ninth_output_bit, output_bits};
    fcf_top #(.DEPTH(DEPTH)) u_fcf_top (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .write_clock(write_clock), .read_clock(read_clock),
        .write_enable_n(write_enable_n), .read_enable_n(read_enable_n), .config_reset(config_reset),
        .input_word(input_word), .output_bits(output_bits), .ninth_output_bit(ninth_output_bit),
        .half_full_flag(half_full_flag), .empty_full_n(empty_full_n),
        .almost_flag_or_cascade_out_n(almost_pin), .cascade_in_n(1'b0),
        .first_load_or_replay(first_load_or_replay));
    fcf_peer u_fcf_peer (.clk_sys(clk_sys), .write_clock(write_clock), .read_clock(read_clock),
        .write_enable_n(write_enable_n), .read_enable_n(read_enable_n), .input_word(input_word),
        .first_load_or_replay(first_load_or_replay));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic final_report();
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        // Only a missing answer counts; a late one on the last try still passes
        if (pready !== 1'b1) begin
            miscompares++;
            final_report();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Config reset level, then time for the synchroniser
    task automatic mr(input logic v);
        config_reset <= v;
        repeat (6) @(posedge clk_sys);
    endtask
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        config_reset = 1'b0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(empty_full_n, 32'h0);
        chk(almost_pin, 32'h0);
        apb(1'b0, FCF_OFS_CFG, 32'h0);
        chk(rd, 32'h010);
        apb(1'b1, 12'h010, 32'h5);
        chk(er, 32'h1);
        // Pin programming: generate mode, threshold four
        mr(1'b1);
        u_fcf_peer.pw(1'b0, 9'h184, 0);
        u_fcf_peer.pw(1'b1, 9'h0AA, 2);
        u_fcf_peer.pr(1'b0, 0);
        chk(q, 32'h184);
        mr(1'b0);
        apb(1'b0, FCF_OFS_CFG, 32'h0);
        chk(rd, 32'h184);
        // Second pass replays what the first pass drained
        for (int p = 0; p < 2; p++) begin
            if (p == 0) for (int i = 0; i < 4; i++) u_fcf_peer.pw(1'b0, rows[i][17:9], i);
            else u_fcf_peer.replay();
            chk(empty_full_n, 32'h0);
            u_fcf_peer.pr(1'b1, 0);
            chk(empty_full_n, 32'h1);
            for (int i = 0; i < 4; i++) begin
                u_fcf_peer.pr(1'b0, 0);
                chk(q, {23'h0, rows[i][8:0]});
            end
        end
        // Check mode flags a stored word whose ninth bit breaks even parity
        mr(1'b1);
        u_fcf_peer.pw(1'b0, 9'h104, 0);
        mr(1'b0);
        u_fcf_peer.pw(1'b0, 9'h001, 0);
        u_fcf_peer.pw(1'b0, 9'h101, 0);
        u_fcf_peer.pr(1'b1, 0);
        u_fcf_peer.pr(1'b0, 0);
        chk(q, 32'h101);
        u_fcf_peer.pr(1'b0, 1);
        chk(q, 32'h001);
        // Fill past full with parity off
        mr(1'b1);
        mr(1'b0);
        apb(1'b1, FCF_OFS_CFG, 32'h004);
        apb(1'b0, FCF_OFS_CFG, 32'h0);
        chk(rd, 32'h004);
        for (int i = 0; i <= DEPTH; i++) begin
            u_fcf_peer.pw(1'b0, i[8:0], 0);
            if (i == DEPTH / 2 - 1) chk(half_full_flag, 32'h0);
            if (i == DEPTH / 2) chk(half_full_flag, 32'h1);
        end
        apb(1'b0, FCF_OFS_LEVEL, 32'h0);
        chk(rd, DEPTH);
        chk(empty_full_n, 32'h0);
        chk(almost_pin, 32'h0);
        u_fcf_peer.pr(1'b1, 0);
        apb(1'b0, FCF_OFS_LEVEL, 32'h0);
        chk(rd, DEPTH);
        u_fcf_peer.pr(1'b0, 0);
        chk(q, 32'h000);
        chk(empty_full_n, 32'h0);
        u_fcf_peer.pw(1'b1, 9'h055, 0);
        chk(empty_full_n, 32'h1);
        apb(1'b0, FCF_OFS_LEVEL, 32'h0);
        chk(rd, DEPTH - 1);
        // Status word: more than half, almost full, not empty, no tokens
        apb(1'b0, FCF_OFS_STAT, 32'h0);
        chk(rd, 32'h006);
        // Cascade mode on a lone strap: pin idles high, writes lack the token
        apb(1'b1, FCF_OFS_CTRL, 32'h1);
        apb(1'b0, FCF_OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        chk(almost_pin, 32'h1);
        u_fcf_peer.pw(1'b0, 9'h0AA, 0);
        apb(1'b0, FCF_OFS_LEVEL, 32'h0);
        chk(rd, DEPTH - 1);
        // Mid-run reset clears level and mode
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(empty_full_n, 32'h0);
        apb(1'b0, FCF_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, FCF_OFS_LEVEL, 32'h0);
        chk(rd, 32'h0);
        final_report();
    end
endmodule // testbench
bind fcf_top fcf_checker u_fcf_checker (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .pready(pready),
    .write_clock(write_clock), .read_clock(read_clock), .read_enable_n(read_enable_n),
    .config_reset(config_reset), .output_bits(output_bits), .ninth_output_bit(ninth_output_bit),
    .half_full_flag(half_full_flag), .empty_full_n(empty_full_n),
    .almost_flag_or_cascade_out_n(almost_flag_or_cascade_out_n));
